// ==== hdl/acis_avl_front.sv ====
// acis_avl_front: waitrequest sequencing for the register slave.
// assumes the master holds a request until it sees waitrequest low.
`timescale 1ns/1ps
module acis_avl_front (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic req,
  output logic      waitrequest,
  output logic      cap,
  output logic      acc
);

  acis_pkg::acis_bus_st_t st_r;

  // one wait state gives time to register read data
  assign waitrequest = req && (st_r == acis_pkg::ACIS_BUS_IDLE);
  assign cap         = req && (st_r == acis_pkg::ACIS_BUS_IDLE);
  assign acc         = req && (st_r == acis_pkg::ACIS_BUS_ANSWER);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_r <= acis_pkg::ACIS_BUS_IDLE;
    end else begin
      unique case (st_r)
        acis_pkg::ACIS_BUS_IDLE: begin
          if (req) begin
            st_r <= acis_pkg::ACIS_BUS_ANSWER;
          end
        end
        acis_pkg::ACIS_BUS_ANSWER: begin
          st_r <= acis_pkg::ACIS_BUS_IDLE;
        end
      endcase
    end
  end

  property p_cap_then_acc;
    @(posedge clk) disable iff (sys_rst)
      cap |=> acc && !waitrequest;
  endproperty
  a_cap_then_acc: assert property (p_cap_then_acc)
    else $error("request not answered one cycle after capture");

endmodule : acis_avl_front

// ==== hdl/acis_irq_group.sv ====
// acis_irq_group: eight sticky status bits with mask and trigger mode.
// assumes sources are synchronous to clk; clr comes from the bus side.
`timescale 1ns/1ps
`include "acis_params.svh"
module acis_irq_group (
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  input  wire logic [7:0]            src,
  input  wire acis_pkg::acis_grp_cfg_t cfg,
  input  wire logic [7:0]            clr,
  output logic      [7:0]            status,
  output logic      [7:0]            evt
);

  logic [7:0] src_d_r;
  logic [7:0] status_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      src_d_r <= `ACIS_RST_VAL;
    end else begin
      src_d_r <= src;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_bit
    acis_pkg::acis_mode_t mode;
    // code is MSB register bit over LSB register bit
    assign mode = acis_pkg::acis_mode_t'({cfg.mode_hi[i], cfg.mode_lo[i]});

    always_comb begin
      unique case (mode)
        acis_pkg::ACIS_MODE_RISE:  evt[i] = src[i] && !src_d_r[i];
        acis_pkg::ACIS_MODE_FALL:  evt[i] = !src[i] && src_d_r[i];
        acis_pkg::ACIS_MODE_LEVEL: evt[i] = src[i];
        acis_pkg::ACIS_MODE_RSVD:  evt[i] = 1'b0;
      endcase
    end

    property p_edge_sets;
      @(posedge clk) disable iff (sys_rst)
        (cfg.mask[i] && evt[i]) ##1 cfg.mask[i] |-> status[i];
    endproperty
    a_edge_sets: assert property (p_edge_sets)
      else $error("enabled event did not set its status bit");

    property p_level_holds;
      @(posedge clk) disable iff (sys_rst)
        (cfg.mask[i] && mode == acis_pkg::ACIS_MODE_LEVEL && src[i] && clr[i])
          ##1 cfg.mask[i] |-> status[i];
    endproperty
    a_level_holds: assert property (p_level_holds)
      else $error("level bit cleared while its source was true");

    property p_masked_blocks;
      @(posedge clk) disable iff (sys_rst)
        !cfg.mask[i] |=> !status_r[i];
    endproperty
    a_masked_blocks: assert property (p_masked_blocks)
      else $error("masked condition reached the status bit");

    property p_rsvd_quiet;
      @(posedge clk) disable iff (sys_rst)
        (mode == acis_pkg::ACIS_MODE_RSVD && !status_r[i] && !src[i])
          [*2] |=> !status_r[i];
    endproperty
    a_rsvd_quiet: assert property (p_rsvd_quiet)
      else $error("reserved code raised a status bit");
  end

  // set wins over clear so an event in the read cycle survives
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= `ACIS_RST_VAL;
    end else begin
      status_r <= cfg.mask & ((status_r & ~clr) | evt);
    end
  end

  assign status = status_r & cfg.mask;

endmodule : acis_irq_group

// ==== hdl/acis_irq_top.sv ====
// acis_irq_top: interrupt status, mask and mode registers of a stereo
// audio transceiver with sample rate converter, on an Avalon-MM slave.
// assumes condition inputs are synchronous single-clock levels or pulses.
// Operation
// - a status bit reads 1 if its condition happened since the last read, else 0.
// - reading a status register clears its bits.
// - a level-mode bit stays 1 after the read while its source is still true.
// - a status bit whose mask bit is 0 always reads 0.
// - with mask 1 the condition sets its status bit and drives the interrupt pin.
// - with mask 0 the condition touches neither status nor the interrupt pin.
// - each mask bit gates the status bit at the same position in its group.
// - the MSB and LSB mode registers give each source a two-bit code, MSB on top.
// - code 00 fires on arrival, 01 on removal, 10 while present, 11 is reserved.
// - status, mask and mode registers all reset to zero.
`timescale 1ns/1ps
`include "acis_params.svh"
module acis_irq_top (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        tx_sample_drop,
  input  wire logic        out_sample_drop,
  input  wire logic        rate_ratio_exceeded,
  input  wire logic        left_overrange,
  input  wire logic        right_overrange,
  input  wire logic        d_to_e_chstat_done,
  input  wire logic        e_to_f_chstat_done,
  input  wire logic        receiver_fault,
  input  wire logic        varispeed_buffer_overflow,
  input  wire logic        rate_tracking_lost,
  input  wire logic        d_to_e_user_transfer_done,
  input  wire logic        e_to_f_user_transfer_done,
  input  wire logic        q_subcode_block_ready,
  input  wire logic        user_fifo_overwrite,
  output logic             irq_out
);

  acis_pkg::acis_bus_req_t req;
  acis_pkg::acis_grp_cfg_t cfg1;
  acis_pkg::acis_grp_cfg_t cfg2;

  logic        bus_cap;
  logic        bus_acc;
  logic        rd_acc;
  logic        wr_acc;
  logic        wr_ok;
  logic [7:0]  g1_src;
  logic [7:0]  g2_src;
  logic [7:0]  g1_status;
  logic [7:0]  g2_status;
  logic [7:0]  g1_evt;
  logic [7:0]  g2_evt;
  logic [7:0]  g1_clr;
  logic [7:0]  g2_clr;
  logic [7:0]  rd_byte;
  logic [7:0]  mask1_r;
  logic [7:0]  mode1_hi_r;
  logic [7:0]  mode1_lo_r;
  logic [7:0]  mask2_r;
  logic [7:0]  mode2_hi_r;
  logic [7:0]  mode2_lo_r;
  logic [7:0]  rd_bits_r;
  logic [31:0] readdata_r;

  // bus request gathered into one bundle; low two address bits ignored
  assign req.rd    = avs_read;
  assign req.wr    = avs_write;
  assign req.idx   = avs_address[7:2];
  assign req.wdata = avs_writedata[7:0];
  assign req.be0   = avs_byteenable[0];

  acis_avl_front u_front (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .req         (req.rd || req.wr),
    .waitrequest (avs_waitrequest),
    .cap         (bus_cap),
    .acc         (bus_acc)
  );

  assign rd_acc = bus_acc && req.rd;
  assign wr_acc = bus_acc && req.wr;
  // registers live in byte lane 0 only
  assign wr_ok  = wr_acc && req.be0;

  // condition inputs packed into their bit positions
  assign g1_src[`ACIS_G1_TX_SLIP]  = tx_sample_drop;
  assign g1_src[`ACIS_G1_OUT_SLIP] = out_sample_drop;
  assign g1_src[`ACIS_G1_RATIO]    = rate_ratio_exceeded;
  assign g1_src[`ACIS_G1_OVR_L]    = left_overrange;
  assign g1_src[`ACIS_G1_OVR_R]    = right_overrange;
  assign g1_src[`ACIS_G1_DE_CS]    = d_to_e_chstat_done;
  assign g1_src[`ACIS_G1_EF_CS]    = e_to_f_chstat_done;
  assign g1_src[`ACIS_G1_RX_FAULT] = receiver_fault;

  assign g2_src[7:6]               = 2'h0;
  assign g2_src[`ACIS_G2_VARISPEED_BUFFER_OVERFLOW]    = varispeed_buffer_overflow;
  assign g2_src[`ACIS_G2_UNLOCK]   = rate_tracking_lost;
  assign g2_src[`ACIS_G2_DE_USER]  = d_to_e_user_transfer_done;
  assign g2_src[`ACIS_G2_EF_USER]  = e_to_f_user_transfer_done;
  assign g2_src[`ACIS_G2_QSUB]     = q_subcode_block_ready;
  assign g2_src[`ACIS_G2_USER_FIFO_OVERWRITE]     = user_fifo_overwrite;

  // mask and mode registers of group 1
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask1_r    <= `ACIS_RST_VAL;
      mode1_hi_r <= `ACIS_RST_VAL;
      mode1_lo_r <= `ACIS_RST_VAL;
    end else if (wr_ok) begin
      if (req.idx == `ACIS_IDX_G1_MASK) begin
        mask1_r <= req.wdata;
      end
      if (req.idx == `ACIS_IDX_G1_MODEH) begin
        mode1_hi_r <= req.wdata;
      end
      if (req.idx == `ACIS_IDX_G1_MODEL) begin
        mode1_lo_r <= req.wdata;
      end
    end
  end

  // mask and mode registers of group 2; missing bits 7:6 stay zero
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mask2_r    <= `ACIS_RST_VAL;
      mode2_hi_r <= `ACIS_RST_VAL;
      mode2_lo_r <= `ACIS_RST_VAL;
    end else if (wr_ok) begin
      if (req.idx == `ACIS_IDX_G2_MASK) begin
        mask2_r <= req.wdata & `ACIS_G2_USED;
      end
      if (req.idx == `ACIS_IDX_G2_MODEH) begin
        mode2_hi_r <= req.wdata & `ACIS_G2_USED;
      end
      if (req.idx == `ACIS_IDX_G2_MODEL) begin
        mode2_lo_r <= req.wdata & `ACIS_G2_USED;
      end
    end
  end

  assign cfg1.mask    = mask1_r;
  assign cfg1.mode_hi = mode1_hi_r;
  assign cfg1.mode_lo = mode1_lo_r;
  assign cfg2.mask    = mask2_r;
  assign cfg2.mode_hi = mode2_hi_r;
  assign cfg2.mode_lo = mode2_lo_r;

  // only the bits that went out in the read data are cleared, so an
  // event landing during the wait state is never lost
  always_comb begin
    g1_clr = 8'h00;
    g2_clr = 8'h00;
    if (rd_acc && req.idx == `ACIS_IDX_G1_STAT) begin
      g1_clr = rd_bits_r;
    end
    if (rd_acc && req.idx == `ACIS_IDX_G2_STAT) begin
      g2_clr = rd_bits_r;
    end
    if (wr_ok && req.idx == `ACIS_IDX_G1_STAT) begin
      g1_clr = req.wdata;
    end
    if (wr_ok && req.idx == `ACIS_IDX_G2_STAT) begin
      g2_clr = req.wdata;
    end
  end

  acis_irq_group u_grp1 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .src     (g1_src),
    .cfg     (cfg1),
    .clr     (g1_clr),
    .status  (g1_status),
    .evt     (g1_evt)
  );

  acis_irq_group u_grp2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .src     (g2_src),
    .cfg     (cfg2),
    .clr     (g2_clr),
    .status  (g2_status),
    .evt     (g2_evt)
  );

  // read mux; unmapped indices read zero
  always_comb begin
    rd_byte = 8'h00;
    unique case (req.idx)
      `ACIS_IDX_G1_STAT:  rd_byte = g1_status;
      `ACIS_IDX_G2_STAT:  rd_byte = g2_status & `ACIS_G2_USED;
      `ACIS_IDX_G1_MASK:  rd_byte = mask1_r;
      `ACIS_IDX_G1_MODEH: rd_byte = mode1_hi_r;
      `ACIS_IDX_G1_MODEL: rd_byte = mode1_lo_r;
      `ACIS_IDX_G2_MASK:  rd_byte = mask2_r;
      `ACIS_IDX_G2_MODEH: rd_byte = mode2_hi_r;
      `ACIS_IDX_G2_MODEL: rd_byte = mode2_lo_r;
      default:            rd_byte = 8'h00;
    endcase
  end

  // read data is taken during the wait state and held through the answer
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_bits_r  <= 8'h00;
      readdata_r <= 32'h0000_0000;
    end else if (bus_cap && req.rd) begin
      rd_bits_r  <= rd_byte;
      readdata_r <= {24'h00_0000, rd_byte};
    end
  end

  assign avs_readdata = readdata_r;

  // status is already masked, so an OR gives the pin directly
  assign irq_out = |{g1_status, g2_status};

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // own disable so the default reset guard cannot silence this check
  property p_reset_clears;
    disable iff (1'b0)
    sys_rst |=> mask1_r == 8'h00 && mode1_hi_r == 8'h00 && mode1_lo_r == 8'h00
      && mask2_r == 8'h00 && g1_status == 8'h00 && g2_status == 8'h00;
  endproperty
  a_reset_clears: assert property (@(posedge clk) p_reset_clears)
    else $error("registers not zero after reset");

  property p_mask_write;
    (wr_ok && req.idx == `ACIS_IDX_G1_MASK) |=> mask1_r == $past(req.wdata);
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("group 1 mask write not taken");

  property p_mode_pair;
    (wr_ok && req.idx == `ACIS_IDX_G1_MODEH) |=> mode1_hi_r == $past(req.wdata)
      && mode1_lo_r == $past(mode1_lo_r);
  endproperty
  a_mode_pair: assert property (p_mode_pair)
    else $error("mode MSB write disturbed the wrong register");

  sequence s_g2_read_quiet;
    rd_acc && req.idx == `ACIS_IDX_G2_STAT && g2_evt == 8'h00;
  endsequence

  property p_read_clears;
    s_g2_read_quiet |=> (g2_status & $past(rd_bits_r)) == 8'h00;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear the reported bits");

  property p_read_reports;
    (bus_cap && req.rd && req.idx == `ACIS_IDX_G2_STAT)
      |=> avs_readdata[7:0] == $past(g2_status) && avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_read_reports: assert property (p_read_reports)
    else $error("status read data does not match the sticky bits");

  property p_masked_reads_zero;
    (bus_cap && req.rd && req.idx == `ACIS_IDX_G1_STAT)
      |=> (avs_readdata[7:0] & ~$past(mask1_r)) == 8'h00;
  endproperty
  a_masked_reads_zero: assert property (p_masked_reads_zero)
    else $error("masked status bit read as one");

  property p_irq_holds;
    (irq_out && !bus_acc) |=> irq_out;
  endproperty
  a_irq_holds: assert property (p_irq_holds)
    else $error("interrupt dropped without a register access");

  property p_irq_quiet;
    (!irq_out && ((g1_evt & mask1_r) == 8'h00) && ((g2_evt & mask2_r) == 8'h00))
      |=> !irq_out;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt rose without an enabled event");

  property p_irq_rises;
    ((g1_evt & mask1_r) != 8'h00) ##1 (mask1_r == $past(mask1_r)) |-> irq_out;
  endproperty
  a_irq_rises: assert property (p_irq_rises)
    else $error("enabled group 1 event did not raise the interrupt");

  property p_wait_once;
    (bus_cap) |-> avs_waitrequest ##1 !avs_waitrequest;
  endproperty
  a_wait_once: assert property (p_wait_once)
    else $error("waitrequest did not fall after one cycle");

  property p_mode_low_write;
    (wr_ok && req.idx == `ACIS_IDX_G1_MODEL) |=> mode1_lo_r == $past(req.wdata)
      && mode1_hi_r == $past(mode1_hi_r);
  endproperty
  a_mode_low_write: assert property (p_mode_low_write)
    else $error("mode LSB write disturbed the wrong register");

  property p_g2_mask_write;
    (wr_ok && req.idx == `ACIS_IDX_G2_MASK)
      |=> mask2_r == ($past(req.wdata) & `ACIS_G2_USED);
  endproperty
  a_g2_mask_write: assert property (p_g2_mask_write)
    else $error("group 2 mask write not taken");

  // write-one-to-clear is a second way out; an event in that cycle still wins
  sequence s_g2_clear_quiet;
    wr_ok && req.idx == `ACIS_IDX_G2_STAT && g2_evt == 8'h00;
  endsequence

  property p_write_clears;
    s_g2_clear_quiet |=> (g2_status & $past(req.wdata)) == 8'h00;
  endproperty
  a_write_clears: assert property (p_write_clears)
    else $error("write of ones did not clear the status bits");

  property p_level_after_read;
    (rd_acc && req.idx == `ACIS_IDX_G1_STAT && (g1_evt & mask1_r) != 8'h00)
      |=> (g1_status & $past(g1_evt & mask1_r)) == $past(g1_evt & mask1_r);
  endproperty
  a_level_after_read: assert property (p_level_after_read)
    else $error("bit with a live source cleared by the read");

  property p_g1_read_reports;
    (bus_cap && req.rd && req.idx == `ACIS_IDX_G1_STAT)
      |=> avs_readdata[7:0] == $past(g1_status) && avs_readdata[31:8] == 24'h00_0000;
  endproperty
  a_g1_read_reports: assert property (p_g1_read_reports)
    else $error("group 1 read data does not match the sticky bits");

  property p_irq_clear;
    (g1_status == 8'h00 && g2_status == 8'h00) |-> !irq_out;
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("interrupt high with every status bit clear");

  property p_wait_idle;
    !(avs_read || avs_write) |-> !avs_waitrequest;
  endproperty
  a_wait_idle: assert property (p_wait_idle)
    else $error("waitrequest high with no request");

endmodule : acis_irq_top

// ==== shared/acis_params.svh ====
// acis_params.svh: offsets, field positions and reset values of the
// audio converter interrupt block.
// assumes word-indexed registers; byte address is four times the index.
`ifndef ACIS_PARAMS_SVH
`define ACIS_PARAMS_SVH

// register indices (byte address = index * 4)
`define ACIS_IDX_G1_STAT  6'h07
`define ACIS_IDX_G2_STAT  6'h08
`define ACIS_IDX_G1_MASK  6'h09
`define ACIS_IDX_G1_MODEH 6'h0A
`define ACIS_IDX_G1_MODEL 6'h0B
`define ACIS_IDX_G2_MASK  6'h0C
`define ACIS_IDX_G2_MODEH 6'h0D
`define ACIS_IDX_G2_MODEL 6'h0E

// reset value of every status, mask and mode register
`define ACIS_RST_VAL 8'h00
// group 2 bits 7:6 do not exist and read as zero
`define ACIS_G2_USED 8'h3F

// group 1 field positions
`define ACIS_G1_TX_SLIP  7
`define ACIS_G1_OUT_SLIP 6
`define ACIS_G1_RATIO    5
`define ACIS_G1_OVR_L    4
`define ACIS_G1_OVR_R    3
`define ACIS_G1_DE_CS    2
`define ACIS_G1_EF_CS    1
`define ACIS_G1_RX_FAULT 0

// group 2 field positions
`define ACIS_G2_VARISPEED_BUFFER_OVERFLOW    5
`define ACIS_G2_UNLOCK   4
`define ACIS_G2_DE_USER  3
`define ACIS_G2_EF_USER  2
`define ACIS_G2_QSUB     1
`define ACIS_G2_USER_FIFO_OVERWRITE     0

`endif

// ==== shared/acis_pkg.sv ====
// acis_pkg: types shared by the interrupt block files.
// assumes acis_params.svh holds all numeric constants.
package acis_pkg;

  // two-bit trigger code, high bit from the MSB mode register
  typedef enum logic [1:0] {
    ACIS_MODE_RISE,
    ACIS_MODE_FALL,
    ACIS_MODE_LEVEL,
    ACIS_MODE_RSVD
  } acis_mode_t;

  // bus front end state
  typedef enum logic {
    ACIS_BUS_IDLE,
    ACIS_BUS_ANSWER
  } acis_bus_st_t;

  // one register access as the slave sees it
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [5:0] idx;
    logic [7:0] wdata;
    logic       be0;
  } acis_bus_req_t;

  // settings of one interrupt group
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] mode_hi;
    logic [7:0] mode_lo;
  } acis_grp_cfg_t;

endpackage : acis_pkg

// ==== tb/audio_converter_interrupt_status_mask_bench.sv ====
// audio_converter_interrupt_status_mask_bench: self-checking bench for acis_irq_top.
// assumes acis_params.svh on the include path and acis_pkg compiled first.
`timescale 1ns/1ps
`include "acis_params.svh"

`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("[FAIL] %s expected %h seen %h", nm, exp, got); \
    end \
  end

module audio_converter_interrupt_status_mask_bench;
  logic        clk;
  logic        sys_rst;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq_out;
  logic [7:0]  g1;
  logic [5:0]  g2;
  int          err_count;
  int          checked;
  logic [7:0]  rd;

  acis_irq_top dut (
    .clk                       (clk),
    .sys_rst                   (sys_rst),
    .avs_address               (avs_address),
    .avs_read                  (avs_read),
    .avs_write                 (avs_write),
    .avs_writedata             (avs_writedata),
    .avs_byteenable            (avs_byteenable),
    .avs_readdata              (avs_readdata),
    .avs_waitrequest           (avs_waitrequest),
    .tx_sample_drop            (g1[7]),
    .out_sample_drop           (g1[6]),
    .rate_ratio_exceeded       (g1[5]),
    .left_overrange            (g1[4]),
    .right_overrange           (g1[3]),
    .d_to_e_chstat_done        (g1[2]),
    .e_to_f_chstat_done        (g1[1]),
    .receiver_fault            (g1[0]),
    .varispeed_buffer_overflow (g2[5]),
    .rate_tracking_lost        (g2[4]),
    .d_to_e_user_transfer_done (g2[3]),
    .e_to_f_user_transfer_done (g2[2]),
    .q_subcode_block_ready     (g2[1]),
    .user_fifo_overwrite       (g2[0]),
    .irq_out                   (irq_out)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // one Avalon access; request held until waitrequest seen low at an edge
  task automatic bus(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                     output logic [7:0] rdat);
    int   n;
    logic busy;
    n    = 0;
    busy = 1'b1;
    rdat = 8'h00;
    avs_address    <= {idx, 2'b00};
    avs_read       <= ~wr;
    avs_write      <= wr;
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= 4'hF;
    // judged where settled, so the edge's own update cannot race the look
    while (busy && n < 16) begin
      @(negedge clk);
      busy = (avs_waitrequest !== 1'b0);
      rdat = avs_readdata[7:0];
      @(posedge clk);
      n++;
    end
    if (busy) err_count++;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so the next request never lands in the same step
    @(posedge clk);
  endtask : bus

  task automatic wreg(input logic [5:0] idx, input logic [7:0] d);
    logic [7:0] dummy;
    bus(1'b1, idx, d, dummy);
  endtask : wreg

  task automatic rreg(input logic [5:0] idx, output logic [7:0] d);
    bus(1'b0, idx, 8'h00, d);
  endtask : rreg

  task automatic pulse1(input logic [7:0] v);
    g1 <= v;
    @(posedge clk);
    g1 <= 8'h00;
    repeat (3) @(posedge clk);
  endtask : pulse1

  task automatic t_reset_vals();
    logic [5:0] idx [9];
    idx = '{`ACIS_IDX_G1_STAT, `ACIS_IDX_G2_STAT, `ACIS_IDX_G1_MASK, `ACIS_IDX_G1_MODEH,
            `ACIS_IDX_G1_MODEL, `ACIS_IDX_G2_MASK, `ACIS_IDX_G2_MODEH, `ACIS_IDX_G2_MODEL,
            6'h20};
    foreach (idx[i]) begin
      rreg(idx[i], rd);
      `CHK("reset value", `ACIS_RST_VAL, rd)
    end
    `CHK("irq after reset", 1'b0, irq_out)
  endtask : t_reset_vals

  task automatic t_masked();
    pulse1(8'hFF);
    `CHK("irq while masked", 1'b0, irq_out)
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("masked status", 8'h00, rd)
    wreg(`ACIS_IDX_G1_MASK, 8'hFE);
    pulse1(8'h01);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("masked bit 0", 8'h00, rd)
    `CHK("irq masked bit", 1'b0, irq_out)
  endtask : t_masked

  task automatic t_rise_walk();
    wreg(`ACIS_IDX_G1_MASK, 8'hFF);
    rreg(`ACIS_IDX_G1_MASK, rd);
    `CHK("mask readback", 8'hFF, rd)
    for (int i = 0; i < 8; i++) begin
      pulse1(8'h01 << i);
      `CHK("irq raised", 1'b1, irq_out)
      rreg(`ACIS_IDX_G1_STAT, rd);
      `CHK("rise status", 8'h01 << i, rd)
      `CHK("irq released", 1'b0, irq_out)
      rreg(`ACIS_IDX_G1_STAT, rd);
      `CHK("cleared on read", 8'h00, rd)
    end
  endtask : t_rise_walk

  task automatic t_fall_and_order();
    wreg(`ACIS_IDX_G1_MODEL, 8'h04);
    rreg(`ACIS_IDX_G1_MODEL, rd);
    `CHK("mode low readback", 8'h04, rd)
    g1 <= 8'h04;
    repeat (3) @(posedge clk);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("fall mode on arrival", 8'h00, rd)
    g1 <= 8'h00;
    repeat (3) @(posedge clk);
    `CHK("irq on removal", 1'b1, irq_out)
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("fall mode on removal", 8'h04, rd)
    pulse1(8'h02);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("neighbour stays rise", 8'h02, rd)
    wreg(`ACIS_IDX_G1_MODEL, 8'h00);
  endtask : t_fall_and_order

  task automatic t_level_reserved();
    wreg(`ACIS_IDX_G1_MODEH, 8'h09);
    wreg(`ACIS_IDX_G1_MODEL, 8'h01);
    g1 <= 8'h08;
    repeat (3) @(posedge clk);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("level first read", 8'h08, rd)
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("level survives read", 8'h08, rd)
    `CHK("irq while level", 1'b1, irq_out)
    g1 <= 8'h00;
    repeat (3) @(posedge clk);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("level sticky after drop", 8'h08, rd)
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("level cleared", 8'h00, rd)
    g1 <= 8'h01;
    repeat (3) @(posedge clk);
    g1 <= 8'h00;
    repeat (3) @(posedge clk);
    rreg(`ACIS_IDX_G1_STAT, rd);
    `CHK("reserved code silent", 8'h00, rd)
    `CHK("irq reserved", 1'b0, irq_out)
  endtask : t_level_reserved

  task automatic t_group2();
    wreg(`ACIS_IDX_G1_MASK, 8'h00);
    wreg(`ACIS_IDX_G2_MASK, 8'h3F);
    for (int i = 0; i < 6; i++) begin
      g2 <= 6'h01 << i;
      @(posedge clk);
      g2 <= 6'h00;
      repeat (3) @(posedge clk);
      `CHK("irq from group 2", 1'b1, irq_out)
      rreg(`ACIS_IDX_G2_STAT, rd);
      `CHK("group 2 status", 8'h01 << i, rd)
      `CHK("irq group 2 clear", 1'b0, irq_out)
    end
    g2 <= 6'h01;
    @(posedge clk);
    g2 <= 6'h00;
    repeat (3) @(posedge clk);
    `CHK("irq before write clear", 1'b1, irq_out)
    wreg(`ACIS_IDX_G2_STAT, 8'h01);
    `CHK("irq after write clear", 1'b0, irq_out)
    rreg(`ACIS_IDX_G2_STAT, rd);
    `CHK("status after write clear", 8'h00, rd)
  endtask : t_group2

  task automatic summarize();
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    err_count      = 0;
    checked        = 0;
    sys_rst        = 1'b1;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h00000000;
    avs_byteenable = 4'h0;
    g1             = 8'h00;
    g2             = 6'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset_vals();
    t_masked();
    t_rise_walk();
    t_fall_and_order();
    t_level_reserved();
    t_group2();
    summarize();
  end
endmodule : audio_converter_interrupt_status_mask_bench
